// ===== hw/step_cfg_bank.sv
// APB register bank for converter A sequence steps 14 and 15.
// Assumes an APB master on clk_i; sequencer polls step14 outputs.
//
// How it works
// R1: Step 14 joins the sequence only while its bit 15 is set.
// R2: Gain bits 14:13: 00 gives 1, 01 gives 2, 10 and 11 give 4.
// R3: Bits 12:5 are reserved, ignore writes and read as zero.
// R4: Bit 4 picks the negative input: 0 analog ground, 1 input seven.
// R5: Positive codes 0000 to 0111 route external inputs zero to seven.
// R6: Codes 1000 to 1111 pick internal sources; negative select is ignored.
// R7: Step 14 register at index 9E, reset value 000E.
// R8: Step 15 register at index 9F, reset value 000F.
// R9: A disabled step is skipped without conversion.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "step_cfg_regs.svh"
module step_cfg_bank (
   input  wire logic              clk_i,
   input  wire logic              resetn_i,
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [11:0]       paddr_i,
   input  wire logic [31:0]       pwdata_i,
   output logic                   pready_o,
   output logic [31:0]            prdata_o,
   output logic                   pslverr_o,
   output logic                   step_fourteen_enable_o,
   output step_cfg_pkg::gain_t    step_fourteen_gain_o,
   output logic                   step_fourteen_neg_input_sel_o,
   output logic [3:0]             step_fourteen_pos_input_sel_o,
   output logic                   step_fourteen_internal_o,
   output logic                   step_fourteen_convert_o
);
   import step_cfg_pkg::*;

   typedef struct packed {
      cfg_word_t   step14;
      cfg_word_t   step15;
      logic        ready;
      logic        slverr;
      logic [31:0] rdata;
      logic        en;
      gain_t       gain;
      logic        neg;
      logic [3:0]  pos;
      logic        internal;
      logic        convert;
   } state_t;

   state_t    st;
   state_t    next_st;
   cfg_word_t view_src;
   logic      access;
   logic      complete;
   logic      hit14;
   logic      hit15;

   // Reads are answered from the access phase; a write commits only at the
   // edge where the master sees pready, so a stalled master never writes.
   assign access   = psel_i && penable_i && !st.ready;
   assign complete = psel_i && penable_i && st.ready;
   // Full byte-address match, so a misaligned address is refused as well.
   assign hit14    = (paddr_i == `STEP14_ADDR); // see R7
   assign hit15    = (paddr_i == `STEP15_ADDR); // see R8

   // Single next-state process: bus answer after one wait, then decode.
   always_comb begin
      next_st = st;
      next_st.ready  = access;
      next_st.slverr = 1'b0;
      next_st.rdata  = 32'h0000_0000;
      if (access) begin
         if (hit14) begin
            next_st.rdata = {16'h0000, st.step14 & `CFG_WRITE_MASK}; // see R3
         end else if (hit15) begin
            next_st.rdata = {16'h0000, st.step15 & `CFG_WRITE_MASK}; // see R3
         end else begin
            // Unmapped words answer with an error and read zero.
            next_st.slverr = 1'b1;
         end
      end
      if (complete && pwrite_i) begin
         if (hit14) begin
            // Reserved bits are masked so they can never hold a one.
            next_st.step14 = pwdata_i[15:0] & `CFG_WRITE_MASK; // see R3
         end else if (hit15) begin
            next_st.step15 = pwdata_i[15:0] & `CFG_WRITE_MASK; // see R8
         end
      end
      // The decoded view lags the word by a clock, except out of reset,
      // where it is taken from the reset word so no stale view escapes.
      view_src = st.step14;
      if (!resetn_i) begin
         next_st        = '0;
         next_st.step14 = `STEP14_RESET; // see R7
         next_st.step15 = `STEP15_RESET; // see R8
         view_src       = `STEP14_RESET;
      end
      // Decoded step 14 view for the sequencer.
      next_st.en = view_src[`CFG_EN_BIT]; // see R1
      unique case (view_src[`CFG_GAIN_HI:`CFG_GAIN_LO])
         2'h0:    next_st.gain = 3'h1; // see R2
         2'h1:    next_st.gain = 3'h2;
         default: next_st.gain = 3'h4;
      endcase
      next_st.pos      = view_src[`CFG_POS_HI:`CFG_POS_LO]; // see R5
      next_st.internal = view_src[`POS_INTERNAL_BIT]; // see R6
      // Internal sources pick their own return path, so force zero here.
      next_st.neg = view_src[`CFG_NEG_BIT] &
                    !view_src[`POS_INTERNAL_BIT]; // see R4 R6
      // A disabled step asks for no conversion and is passed over.
      next_st.convert = view_src[`CFG_EN_BIT]; // see R9
   end

   // State register; the synchronous reset is folded into next_st above.
   always_ff @(posedge clk_i) begin
      st <= next_st;
   end

   assign pready_o  = st.ready;
   assign prdata_o  = st.rdata;
   assign pslverr_o = st.slverr;
   assign step_fourteen_enable_o        = st.en;
   assign step_fourteen_gain_o          = st.gain;
   assign step_fourteen_neg_input_sel_o = st.neg;
   assign step_fourteen_pos_input_sel_o = st.pos;
   assign step_fourteen_internal_o      = st.internal;
   assign step_fourteen_convert_o       = st.convert;

   // Two steps of one transfer: the access phase is taken, then answered.
   sequence s_taken;
      psel_i && penable_i && !pready_o;
   endsequence

   sequence s_answered;
      psel_i && penable_i && pready_o;
   endsequence

   // A read of one configuration word, taken and answered on the next edge.
   sequence s_read14;
      s_taken ##0 (!pwrite_i && paddr_i == `STEP14_ADDR) ##1 s_answered;
   endsequence

   sequence s_read15;
      s_taken ##0 (!pwrite_i && paddr_i == `STEP15_ADDR) ##1 s_answered;
   endsequence

   // A write to the step 14 word at the edge where it commits.
   sequence s_write14;
      s_answered ##0 (pwrite_i && paddr_i == `STEP14_ADDR);
   endsequence

   property p_reserved_zero;
      @(posedge clk_i) disable iff (!resetn_i)
         pready_o |-> prdata_o[12:5] == 8'h00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) // see R3
      else $error("Reserved bits read nonzero.");

   property p_enable_follows;
      @(posedge clk_i) disable iff (!resetn_i)
         ##1 step_fourteen_enable_o == $past(st.step14[15]);
   endproperty
   a_enable_follows: assert property (p_enable_follows) // see R1
      else $error("Enable output does not follow bit 15.");

   property p_gain_map;
      @(posedge clk_i) disable iff (!resetn_i)
         ##1 step_fourteen_gain_o ==
            ($past(st.step14[14:13]) == 2'h0 ? 3'h1 :
             $past(st.step14[14:13]) == 2'h1 ? 3'h2 : 3'h4);
   endproperty
   a_gain_map: assert property (p_gain_map) // see R2
      else $error("Gain decode wrong.");

   property p_neg_ignored;
      @(posedge clk_i) disable iff (!resetn_i)
         step_fourteen_internal_o |-> !step_fourteen_neg_input_sel_o;
   endproperty
   a_neg_ignored: assert property (p_neg_ignored) // see R6
      else $error("Negative select used with internal source.");

   property p_write_read;
      @(posedge clk_i) disable iff (!resetn_i)
         s_write14 |=>
            st.step14 == ($past(pwdata_i[15:0]) & `CFG_WRITE_MASK);
   endproperty
   a_write_read: assert property (p_write_read) // see R3
      else $error("Step 14 readback mismatch.");

   property p_skip;
      @(posedge clk_i) disable iff (!resetn_i)
         !step_fourteen_enable_o |-> !step_fourteen_convert_o;
   endproperty
   a_skip: assert property (p_skip) // see R9
      else $error("Disabled step requests conversion.");

   property p_pos_route;
      @(posedge clk_i) disable iff (!resetn_i)
         ##1 step_fourteen_pos_input_sel_o == $past(st.step14[3:0]);
   endproperty
   a_pos_route: assert property (p_pos_route) // see R5
      else $error("Positive select does not follow field.");

   property p_ready_one;
      @(posedge clk_i) disable iff (!resetn_i)
         pready_o |=> !pready_o;
   endproperty
   a_ready_one: assert property (p_ready_one) // one wait state per transfer, bus handshake
      else $error("Ready held longer than one cycle.");

   property p_read14;
      @(posedge clk_i) disable iff (!resetn_i)
         s_read14 |-> prdata_o == {16'h0000, $past(st.step14)} && !pslverr_o;
   endproperty
   a_read14: assert property (p_read14) // see R7
      else $error("Step 14 word not returned at its address.");

   property p_read15;
      @(posedge clk_i) disable iff (!resetn_i)
         s_read15 |-> prdata_o == {16'h0000, $past(st.step15)} && !pslverr_o;
   endproperty
   a_read15: assert property (p_read15) // see R8
      else $error("Step 15 word not returned at its address.");

   // Any other address is refused and must not leak register contents.
   property p_unmapped;
      @(posedge clk_i) disable iff (!resetn_i)
         s_taken ##0 (paddr_i != `STEP14_ADDR && paddr_i != `STEP15_ADDR)
            ##1 s_answered |-> pslverr_o && prdata_o == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped) // see R7 R8
      else $error("Unmapped address not refused.");

   property p_reset_words;
      @(posedge clk_i) disable iff (!resetn_i)
         $rose(resetn_i) |-> st.step14 == `STEP14_RESET &&
            st.step15 == `STEP15_RESET && !step_fourteen_convert_o;
   endproperty
   a_reset_words: assert property (p_reset_words) // see R7 R8
      else $error("Configuration words not at reset values.");

   property p_neg_route;
      @(posedge clk_i) disable iff (!resetn_i)
         $past(resetn_i) && !step_fourteen_internal_o |->
            step_fourteen_neg_input_sel_o == $past(st.step14[`CFG_NEG_BIT]);
   endproperty
   a_neg_route: assert property (p_neg_route) // see R4
      else $error("Negative select does not follow its bit.");

   property p_internal_flag;
      @(posedge clk_i) disable iff (!resetn_i)
         $past(resetn_i) |-> step_fourteen_internal_o ==
            $past(st.step14[`POS_INTERNAL_BIT]);
   endproperty
   a_internal_flag: assert property (p_internal_flag) // see R6
      else $error("Internal source flag does not follow the code.");
endmodule
`default_nettype wire

// ===== hw/step_cfg_pkg.sv
// Types shared by the step configuration block.
// Assumes the constants header is on the include path.
`default_nettype none
package step_cfg_pkg;
   typedef logic [15:0] cfg_word_t;
   typedef logic [2:0]  gain_t;
endpackage
`default_nettype wire

// ===== hw/step_cfg_regs.svh
// Register map constants for the converter A step 14 and 15 configuration.
// Assumes inclusion by bare name from the design file and the testbench.
`ifndef STEP_CFG_REGS_SVH
`define STEP_CFG_REGS_SVH
`define STEP14_INDEX     8'h9E
`define STEP15_INDEX     8'h9F
`define STEP14_ADDR      12'h278
`define STEP15_ADDR      12'h27C
`define STEP14_RESET     16'h000E
`define STEP15_RESET     16'h000F
`define CFG_WRITE_MASK   16'hE01F
`define CFG_EN_BIT       15
`define CFG_GAIN_HI      14
`define CFG_GAIN_LO      13
`define CFG_NEG_BIT      4
`define CFG_POS_HI       3
`define CFG_POS_LO       0
`define POS_INTERNAL_BIT 3
`define SRC_ENABLE_ADDR  10'h280
`define SRC_ENABLE_RESET 8'h00
`endif

// ===== test/test_step_cfg_bank.sv
// Testbench for the step 14 and 15 configuration bank, over APB.
// Assumes the design header is on the include path and a 100 MHz clock.
`timescale 1ns/1ns
`default_nettype none
`include "step_cfg_regs.svh"
module test_step_cfg_bank;
   import step_cfg_pkg::*;
   logic        clk_i, resetn_i, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        en, ng, pi, cv, err;
   gain_t       gn;
   logic [3:0]  ps, p;
   logic [15:0] w;
   int          mismatches, checks;
   step_cfg_bank u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata),
      .pslverr_o(pslverr), .step_fourteen_enable_o(en),
      .step_fourteen_gain_o(gn), .step_fourteen_neg_input_sel_o(ng),
      .step_fourteen_pos_input_sel_o(ps), .step_fourteen_internal_o(pi),
      .step_fourteen_convert_o(cv));
   // Free-running clock, 10 ns period.
   always #5 clk_i = ~clk_i;
   task finish_test();
      if (mismatches == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task check(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // One APB transfer; the wait is bounded so a silent slave cannot hang us.
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (n >= 20) begin
         mismatches++;
         $display("MISMATCH %0t no pready", $time);
         finish_test();
      end
   endtask
   // Outputs are checked two clocks after the task is called, as decode lags a clock.
   task outs(input logic e, input gain_t g, input logic n, input logic [3:0] q);
      repeat (2) @(posedge clk_i);
      check(32'(en), 32'(e), "enable");
      check(32'(cv), 32'(e), "convert");
      check(32'(gn), 32'(g), "gain");
      check(32'(ng), 32'(q[3] ? 1'b0 : n), "neg");
      check(32'(ps), 32'(q), "pos");
      check(32'(pi), 32'(q[3]), "internal");
   endtask
   initial begin
      clk_i = 1'b0;
      resetn_i = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h0000_0000; mismatches = 0; checks = 0;
      repeat (2) @(posedge clk_i);
      resetn_i <= 1'b1;
      outs(1'b0, 3'h1, 1'b0, 4'hE);
      apb(1'b0, 12'(`STEP14_ADDR), 32'h0);
      check(rd, 32'h0000_000E, "step14 reset");
      apb(1'b0, 12'(`STEP15_ADDR), 32'h0);
      check(rd, 32'h0000_000F, "step15 reset");
      // Every positive code, every gain code, with reserved bits all set.
      for (int c = 0; c < 16; c++) begin
         p = c[3:0];
         w = {p[2], p[1:0], 8'hFF, ~p[0], p};
         apb(1'b1, 12'(`STEP14_ADDR), {16'hFFFF, w});
         apb(1'b0, 12'(`STEP14_ADDR), 32'h0);
         check(rd, {16'h0000, w & 16'hE01F}, "step14 read");
         outs(p[2], p[1:0] == 2'h0 ? 3'h1 : p[1:0] == 2'h1 ? 3'h2 : 3'h4,
              ~p[0], p);
      end
      apb(1'b1, 12'(`STEP15_ADDR), 32'h0000_FFF4);
      apb(1'b0, 12'(`STEP15_ADDR), 32'h0);
      check(rd, 32'h0000_E014, "step15 read");
      check(32'(err), 32'h0000_0000, "mapped err");
      apb(1'b0, 12'h274, 32'h0);
      check({rd[30:0], err}, 32'h0000_0001, "unmapped");
      // A reset in mid-run must bring both words back to their reset values.
      @(posedge clk_i);
      resetn_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      resetn_i <= 1'b1;
      outs(1'b0, 3'h1, 1'b0, 4'hE);
      apb(1'b0, 12'(`STEP14_ADDR), 32'h0);
      check(rd, 32'h0000_000E, "step14 mid reset");
      apb(1'b0, 12'(`STEP15_ADDR), 32'h0);
      check(rd, 32'h0000_000F, "step15 mid reset");
      finish_test();
   end
endmodule
`default_nettype wire
